// ---- cfg5_properties.sv ----
`timescale 1ns/10ps
module cfg5_chk (
    input wire clock_i,
    input wire resetn_i,
    input wire [7:0] reg_addr_i,
    input wire reg_write_i,
    input wire [7:0] reg_wdata_i,
    input wire config_lock_i,
    input wire [7:0] reg_rdata_o,
    input wire twos_complement_select_o,
    input wire offset_range_select_o,
    input wire spare_io_enable_i,
    input wire spare_io_pin_oe_o,
    input wire [7:0] remote_one_limit_i,
    input wire [7:0] local_limit_i,
    input wire [7:0] remote_two_limit_i,
    input wire overtemp_pin_oe_o
);
    wire wr = reg_write_i && reg_addr_i == 8'h7c;
    wire [7:0] m = twos_complement_select_o ? 8'h80 : 8'h00;
    wire mn = remote_one_limit_i == m && local_limit_i == m &&
        remote_two_limit_i == m;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    a_format_write: assert property (wr && !config_lock_i |=>
        twos_complement_select_o == $past(reg_wdata_i[0])) else $error("fmt");
    a_range_write: assert property (wr && !config_lock_i |=>
        offset_range_select_o == $past(reg_wdata_i[1])) else $error("rng");
    a_lock_keeps: assert property (wr && config_lock_i |=>
        $stable({offset_range_select_o, twos_complement_select_o}))
        else $error("lock");
    a_read_data: assert property (reg_addr_i == 8'h7c |=>
        reg_rdata_o[1:0] == $past({offset_range_select_o,
        twos_complement_select_o})) else $error("rdata");
    a_read_other: assert property (reg_addr_i != 8'h7c |=>
        reg_rdata_o == 8'h00) else $error("rdata other");
    a_reset_value: assert property ($rose(resetn_i) |->
        {offset_range_select_o, twos_complement_select_o} == 2'b01)
        else $error("reset");
    a_spare_oe: assert property (spare_io_pin_oe_o |->
        $past(spare_io_enable_i)) else $error("spare oe");
    a_min_limit: assert property (mn [*3] |-> !overtemp_pin_oe_o)
        else $error("min limit");
endmodule
bind thermal_config_register_five cfg5_chk cfg5_chk_i (.clock_i, .resetn_i,
    .reg_addr_i, .reg_write_i, .reg_wdata_i, .config_lock_i, .reg_rdata_o,
    .twos_complement_select_o, .offset_range_select_o, .spare_io_enable_i,
    .spare_io_pin_oe_o, .remote_one_limit_i, .local_limit_i,
    .remote_two_limit_i, .overtemp_pin_oe_o);

// ---- overtemp_channel.v ----
`timescale 1ns/10ps
`include "thermal_cfg5_defs.vh"
module overtemp_channel (
    input wire clock_i,
    input wire resetn_i,
    input wire twos_complement_select_i,
    input wire drive_enable_i,
    input wire [7:0] temp_i,
    input wire [7:0] limit_i,
    output reg trip_o
);
    reg [7:0] temp_b;
    reg [7:0] limit_b;
    reg limit_is_min;
    always @* begin
        if (twos_complement_select_i) begin
            temp_b = temp_i ^ 8'h80;
            limit_b = limit_i ^ 8'h80;
            limit_is_min = (limit_i == `TWOS_MIN);
        end else begin
            temp_b = temp_i;
            limit_b = limit_i;
            limit_is_min = (limit_i == `OFFSET64_MIN);
        end
    end
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            trip_o <= 1'b0;
        end else begin
            trip_o <= drive_enable_i && !limit_is_min && (temp_b > limit_b);
        end
    end
endmodule

// ---- sync2.v ----
`timescale 1ns/10ps
module sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clock_i,
    input wire resetn_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage;
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            // idle level of the pin, so no false edge follows reset
            stage <= INIT;
            sync_o <= INIT;
        end else begin
            stage <= async_i;
            sync_o <= stage;
        end
    end
endmodule

// ---- thermal_cfg5_defs.vh ----
`ifndef THERMAL_CFG5_DEFS_VH
`define THERMAL_CFG5_DEFS_VH

`define CFG5_OFFSET 8'h7c
`define CFG5_RESET 8'h01
`define CFG5_TWOS_BIT 0
`define CFG5_RANGE_BIT 1
`define CFG5_DIR_BIT 2
`define CFG5_POL_BIT 3
`define CFG5_FUNC_BIT 4
`define CFG5_R1_BIT 5
`define CFG5_LOC_BIT 6
`define CFG5_R2_BIT 7
`define OFFSET64_MIN 8'h00
`define TWOS_MIN 8'h80
`define OFFSET64_BIAS 8'h40
`define OVERTEMP_IDLE 1'b1
`define SPARE_IDLE 1'b0
`define SHARED_IDLE 5'h00

`endif

// ---- thermal_config_register_five.v ----
`timescale 1ns/10ps
`include "thermal_cfg5_defs.vh"
module thermal_config_register_five (
    input wire clock_i,
    input wire resetn_i,
    input wire [7:0] reg_addr_i,
    input wire reg_write_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    input wire config_lock_i,
    input wire [7:0] remote_one_temp_i,
    input wire [7:0] local_temp_i,
    input wire [7:0] remote_two_temp_i,
    input wire [7:0] remote_one_limit_i,
    input wire [7:0] local_limit_i,
    input wire [7:0] remote_two_limit_i,
    input wire [7:0] offset_code_i,
    output reg [8:0] offset_half_degrees_o,
    output wire twos_complement_select_o,
    output wire offset_range_select_o,
    input wire spare_io_pin_i,
    input wire spare_io_level_i,
    input wire spare_io_enable_i,
    output reg spare_io_pin_o,
    output reg spare_io_pin_oe_o,
    output reg spare_io_read_o,
    input wire [4:0] shared_pins_i,
    output reg [4:0] cpu_voltage_id_code_o,
    output reg [4:0] shared_gpio_in_o,
    input wire overtemp_pin_i,
    output wire overtemp_pin_o,
    output reg overtemp_pin_oe_o,
    output wire overtemp_timer_input_o
);
    reg [7:0] cfg;
    reg [7:0] next_cfg;
    reg [7:0] next_rdata;
    reg [8:0] next_offset_half_degrees;
    reg next_spare_io_pin;
    reg next_spare_io_pin_oe;
    reg next_spare_io_read;
    reg [4:0] next_cpu_voltage_id_code;
    reg [4:0] next_shared_gpio_in;
    reg next_overtemp_pin_oe;
    wire [4:0] shared_sync;
    wire spare_sync;
    wire overtemp_sync;
    wire trip_r1;
    wire trip_loc;
    wire trip_r2;
    wire cfg_hit;
    wire cfg_write;
    wire write_accepted;
    wire twos_complement_select;
    wire offset_range_select;
    wire spare_io_direction;
    wire spare_io_polarity;
    wire cpu_code_pin_function_select;
    wire remote_one_overtemp_drive_enable;
    wire local_overtemp_drive_enable;
    wire remote_two_overtemp_drive_enable;
    wire [8:0] offset_fine;
    wire [8:0] offset_coarse;
    wire spare_io_drive;
    wire any_trip;

    // one decode serves both the write and the read path
    assign cfg_hit = (reg_addr_i == `CFG5_OFFSET);
    assign cfg_write = reg_write_i && cfg_hit;
    assign write_accepted = cfg_write && !config_lock_i;

    always @* begin
        next_cfg = cfg;
        if (write_accepted) begin
            next_cfg = reg_wdata_i;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            cfg <= `CFG5_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    assign twos_complement_select = cfg[`CFG5_TWOS_BIT];
    assign offset_range_select = cfg[`CFG5_RANGE_BIT];
    assign spare_io_direction = cfg[`CFG5_DIR_BIT];
    assign spare_io_polarity = cfg[`CFG5_POL_BIT];
    assign cpu_code_pin_function_select = cfg[`CFG5_FUNC_BIT];
    assign remote_one_overtemp_drive_enable = cfg[`CFG5_R1_BIT];
    assign local_overtemp_drive_enable = cfg[`CFG5_LOC_BIT];
    assign remote_two_overtemp_drive_enable = cfg[`CFG5_R2_BIT];
    assign twos_complement_select_o = twos_complement_select;
    assign offset_range_select_o = offset_range_select;

    // other offsets belong to neighbouring registers
    always @* begin
        next_rdata = 8'h00;
        if (cfg_hit) begin
            next_rdata = cfg;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // offset in half degrees
    // coarse step doubles the code; bit 8 keeps the sign
    assign offset_fine = {offset_code_i[7], offset_code_i};
    assign offset_coarse = {offset_code_i, 1'b0};

    always @* begin
        if (offset_range_select) begin
            next_offset_half_degrees = offset_coarse;
        end else begin
            next_offset_half_degrees = offset_fine;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            offset_half_degrees_o <= 9'h000;
        end else begin
            offset_half_degrees_o <= next_offset_half_degrees;
        end
    end

    // pins come from outside the clock domain
    // flops reset to idle level: no false assertion after reset
    sync2 #(
        .WIDTH(1),
        .INIT(`OVERTEMP_IDLE)
    ) overtemp_pin_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i(overtemp_pin_i),
        .sync_o(overtemp_sync)
    );

    sync2 #(
        .WIDTH(1),
        .INIT(`SPARE_IDLE)
    ) spare_pin_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i(spare_io_pin_i),
        .sync_o(spare_sync)
    );

    sync2 #(
        .WIDTH(5),
        .INIT(`SHARED_IDLE)
    ) shared_pin_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i(shared_pins_i),
        .sync_o(shared_sync)
    );

    assign spare_io_drive = spare_io_polarity ? spare_io_level_i
                                              : ~spare_io_level_i;

    // drive only when enabled as output
    always @* begin
        next_spare_io_pin_oe = spare_io_enable_i && spare_io_direction;
    end

    always @* begin
        next_spare_io_pin = spare_io_drive;
    end

    // input level stays readable in either direction
    always @* begin
        next_spare_io_read = spare_sync;
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            spare_io_pin_oe_o <= 1'b0;
        end else begin
            spare_io_pin_oe_o <= next_spare_io_pin_oe;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            spare_io_pin_o <= 1'b0;
        end else begin
            spare_io_pin_o <= next_spare_io_pin;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            spare_io_read_o <= 1'b0;
        end else begin
            spare_io_read_o <= next_spare_io_read;
        end
    end

    // unselected output keeps its last value
    always @* begin
        next_cpu_voltage_id_code = cpu_voltage_id_code_o;
        next_shared_gpio_in = shared_gpio_in_o;
        if (cpu_code_pin_function_select) begin
            next_shared_gpio_in = shared_sync;
        end else begin
            next_cpu_voltage_id_code = shared_sync;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            cpu_voltage_id_code_o <= 5'h00;
        end else begin
            cpu_voltage_id_code_o <= next_cpu_voltage_id_code;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            shared_gpio_in_o <= 5'h00;
        end else begin
            shared_gpio_in_o <= next_shared_gpio_in;
        end
    end

    overtemp_channel ch_r1 (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .twos_complement_select_i(twos_complement_select),
        .drive_enable_i(remote_one_overtemp_drive_enable),
        .temp_i(remote_one_temp_i),
        .limit_i(remote_one_limit_i),
        .trip_o(trip_r1)
    );
    overtemp_channel ch_loc (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .twos_complement_select_i(twos_complement_select),
        .drive_enable_i(local_overtemp_drive_enable),
        .temp_i(local_temp_i),
        .limit_i(local_limit_i),
        .trip_o(trip_loc)
    );
    overtemp_channel ch_r2 (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .twos_complement_select_i(twos_complement_select),
        .drive_enable_i(remote_two_overtemp_drive_enable),
        .temp_i(remote_two_temp_i),
        .limit_i(remote_two_limit_i),
        .trip_o(trip_r2)
    );

    // any channel may pull the shared pin
    assign any_trip = trip_r1 | trip_loc | trip_r2;

    // open drain, active low: only ever pulls down
    assign overtemp_pin_o = 1'b0;

    always @* begin
        next_overtemp_pin_oe = any_trip;
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            overtemp_pin_oe_o <= 1'b0;
        end else begin
            overtemp_pin_oe_o <= next_overtemp_pin_oe;
        end
    end

    // low pin level means asserted
    assign overtemp_timer_input_o = ~overtemp_sync;
endmodule

// ---- thermal_config_register_five_tb.sv ----
`timescale 1ns/10ps
module thermal_config_register_five_tb;
    reg clock_i = 0, resetn_i = 0, reg_write_i = 0, config_lock_i = 0;
    reg spare_io_pin_i = 0, spare_io_level_i = 0, spare_io_enable_i = 0;
    reg overtemp_pin_i = 1;
    reg [7:0] reg_addr_i = 0, reg_wdata_i = 0, offset_code_i = 0;
    reg [7:0] remote_one_temp_i = 0, local_temp_i = 0, remote_two_temp_i = 0;
    reg [7:0] remote_one_limit_i = 0, local_limit_i = 0;
    reg [7:0] remote_two_limit_i = 0;
    reg [4:0] shared_pins_i = 0;
    wire [7:0] reg_rdata_o;
    wire [8:0] offset_half_degrees_o;
    wire [4:0] cpu_voltage_id_code_o, shared_gpio_in_o;
    wire twos_complement_select_o, offset_range_select_o, spare_io_pin_o;
    wire spare_io_pin_oe_o, spare_io_read_o, overtemp_pin_o;
    wire overtemp_pin_oe_o, overtemp_timer_input_o;
    integer n_errors = 0, n_compared = 0, k;
    thermal_config_register_five thermal_config_register_five_i (.clock_i,
        .resetn_i, .reg_addr_i, .reg_write_i, .reg_wdata_i, .reg_rdata_o,
        .config_lock_i, .remote_one_temp_i, .local_temp_i, .remote_two_temp_i,
        .remote_one_limit_i, .local_limit_i, .remote_two_limit_i,
        .offset_code_i, .offset_half_degrees_o, .twos_complement_select_o,
        .offset_range_select_o, .spare_io_pin_i, .spare_io_level_i,
        .spare_io_enable_i, .spare_io_pin_o, .spare_io_pin_oe_o,
        .spare_io_read_o, .shared_pins_i, .cpu_voltage_id_code_o,
        .shared_gpio_in_o, .overtemp_pin_i, .overtemp_pin_o,
        .overtemp_pin_oe_o, .overtemp_timer_input_o);
    always #10 clock_i = ~clock_i;
    task test_done; begin
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    end endtask
    task chk(input [9:0] s, input [9:0] e); begin
        n_compared = n_compared + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    end endtask
    task wr(input [7:0] a, input [7:0] d); begin
        reg_addr_i = a; reg_wdata_i = d; reg_write_i = 1;
        @(negedge clock_i); reg_write_i = 0;
    end endtask
    task rd(input [7:0] a, input [7:0] e); begin
        reg_addr_i = a; @(negedge clock_i); chk(reg_rdata_o, e);
    end endtask
    // write then let synced paths settle
    task ws(input [7:0] c); begin
        wr(8'h7c, c); repeat (4) @(negedge clock_i);
    end endtask
    task ot(input [7:0] c, input [7:0] t, input [7:0] l, input e); begin
        {remote_one_temp_i, local_temp_i, remote_two_temp_i} =
            {t, 16'h0} >> (8 * k);
        {remote_one_limit_i, local_limit_i, remote_two_limit_i} = {3{l}};
        ws(c); chk(overtemp_pin_oe_o, e);
    end endtask
    initial begin
        #20000 n_errors = n_errors + 1;
        test_done;
    end
    initial begin
        repeat (16) @(negedge clock_i);
        resetn_i = 1;
        chk(overtemp_timer_input_o, 0);
        rd(8'h7c, 8'h01);
        rd(8'h7b, 8'h00);
        for (k = 0; k < 8; k = k + 1) begin
            wr(8'h7c, 8'h1 << k); rd(8'h7c, 8'h1 << k);
            chk({twos_complement_select_o, offset_range_select_o},
                {k == 0, k == 1});
        end
        config_lock_i = 1; wr(8'h7c, 8'hff); rd(8'h7c, 8'h80);
        config_lock_i = 0; wr(8'h7b, 8'hff); rd(8'h7c, 8'h80);
        offset_code_i = 8'h05; ws(8'h00); chk(offset_half_degrees_o, 5);
        ws(8'h02); chk(offset_half_degrees_o, 10);
        offset_code_i = 8'hfb;
        ws(8'h00); chk(offset_half_degrees_o, 10'h1fb);
        ws(8'h02); chk(offset_half_degrees_o, 10'h1f6);
        spare_io_enable_i = 1; spare_io_level_i = 1;
        ws(8'h04); chk({spare_io_pin_oe_o, spare_io_pin_o}, 2);
        ws(8'h0c); chk({spare_io_pin_oe_o, spare_io_pin_o}, 3);
        ws(8'h08); chk(spare_io_pin_oe_o, 0);
        shared_pins_i = 5'h15; ws(8'h00);
        chk(cpu_voltage_id_code_o, 5'h15);
        shared_pins_i = 5'h0a; ws(8'h10);
        chk({cpu_voltage_id_code_o, shared_gpio_in_o}, 10'h2aa);
        overtemp_pin_i = 0;
        spare_io_pin_i = 1;
        repeat (3) @(negedge clock_i);
        chk({overtemp_timer_input_o, spare_io_read_o, overtemp_pin_o},
            3'b110);
        overtemp_pin_i = 1;
        for (k = 0; k < 3; k = k + 1) begin
            ot((8'h20 << k) | 8'h01, 8'h50, 8'h40, 1);
            ot((8'h20 << k) | 8'h01, 8'h90, 8'h40, 0);
            ot(8'h20 << k, 8'h90, 8'h40, 1);
            ot(8'h20 << k, 8'h90, 8'h00, 0);
            ot((8'h20 << k) | 8'h01, 8'h50, 8'h80, 0);
            ot(8'h01, 8'h50, 8'h40, 0);
        end
        test_done;
    end
endmodule
